/* File: sfc_defines.vh */
// Constants of the serial flash command framer: opcodes, field layout and power-up timing.
// Behaviour
// - Addressed opcodes take three address bytes: six reserved, nine page, nine byte bits.
// - 53h 58h 60h 81h 83h 88h use page only; 50h upper five; 77h 7Ch none.
// - 84h D1h D4h use byte field only; 03h 0Bh 82h D2h E8h use both.
// - Extra don't-care bytes: one for 0Bh and D4h, four for D2h and E8h.
// - After power-up or reset the serial clock mode defaults to mode 3.
// - After power-up or reset the data output stays high impedance.
// - Decoding starts only after a chip-select falling edge.
// - Each chip-select falling edge picks mode 0 or 3 from the idle clock level.
// - While power-on reset is active all commands are ignored.
// - Writes are accepted at most 20 ms after power-on reset releases.
// - After power-up the device rests in standby until a command arrives.
// - 53h transfers page to buffer, 60h compares, 58h rewrites through buffer.
// - B9h enters deep power-down, ABh resumes from it.
// - D7h reads status, 9Fh reads manufacturer and device identity.
`ifndef SFC_DEFINES_VH
`define SFC_DEFINES_VH
`define SFC_OP_MAIN_READ   8'h03
`define SFC_OP_FAST_READ   8'h0b
`define SFC_OP_BLOCK_ERASE 8'h50
`define SFC_OP_PAGE_XFER   8'h53
`define SFC_OP_REWRITE     8'h58
`define SFC_OP_COMPARE     8'h60
`define SFC_OP_SEC_READ    8'h77
`define SFC_OP_SECT_ERASE  8'h7c
`define SFC_OP_PAGE_ERASE  8'h81
`define SFC_OP_PROG_BUF    8'h82
`define SFC_OP_BUF_PROG_E  8'h83
`define SFC_OP_BUF_WRITE   8'h84
`define SFC_OP_BUF_PROG    8'h88
`define SFC_OP_IDENT       8'h9f
`define SFC_OP_DEEP_DOWN   8'hb9
`define SFC_OP_RESUME      8'hab
`define SFC_OP_BUF_READ_L  8'hd1
`define SFC_OP_ARRAY_READ  8'hd2
`define SFC_OP_BUF_READ    8'hd4
`define SFC_OP_STATUS      8'hd7
`define SFC_OP_ARRAY_CONT  8'he8
`define SFC_PAGE_MSB       17
`define SFC_PAGE_LSB       9
`define SFC_BYTE_MSB       8
`define SFC_ADDR_BYTES     3
`define SFC_CLK_HZ         25000000
`define SFC_PUW_MS         20
`define SFC_PUW_CYCLES     ((`SFC_PUW_MS * `SFC_CLK_HZ) / 1000)
`endif

/* File: sfc_sync.v */
// Two-stage synchroniser for a group of pins.
`timescale 1ns/100ps
`default_nettype none
module sfc_sync #(
  parameter W = 3
) (
  input  wire         clk,
  input  wire         rst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta_r;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* File: sfc_frame.v */
// Command framer of the serial flash: opcode, address and dummy-byte capture.
`timescale 1ns/100ps
`include "sfc_defines.vh"
`default_nettype none
module sfc_frame #(
  parameter PUW_CYCLES = `SFC_PUW_CYCLES
) (
  input  wire        sys_clk,
  input  wire        sys_rst,
  input  wire        por_active,
  input  wire        cs_n,
  input  wire        sck,
  input  wire        si,
  output reg         so_out,
  output reg         so_oe,
  output reg         mode3_r,
  output reg         standby_r,
  output reg         write_ready_r,
  output reg         deep_down_r,
  output reg         cmd_valid_r,
  output reg  [7:0]  cmd_op_r,
  output reg  [8:0]  page_addr_r,
  output reg  [8:0]  byte_addr_r,
  output reg         use_page_r,
  output reg         use_byte_r,
  output reg         cmd_illegal_r
);
  ////////////////////////////////////////////////////////////////////////////
  localparam S_IDLE = 4'b0001;
  localparam S_OP   = 4'b0010;
  localparam S_ADDR = 4'b0100;
  localparam S_DUMY = 4'b1000;

  // Opcode classes: {addressed, page used, byte used, dummy count[2:0]}.
  // The six reserved address bits are never decoded, whatever the opcode.
  function [5:0] op_class;
    input [7:0] op;
    begin
      case (op)
        `SFC_OP_MAIN_READ, `SFC_OP_PROG_BUF:           op_class = 6'h38;
        `SFC_OP_FAST_READ:                             op_class = 6'h39;
        `SFC_OP_ARRAY_READ, `SFC_OP_ARRAY_CONT:        op_class = 6'h3c;
        `SFC_OP_BUF_WRITE, `SFC_OP_BUF_READ_L:         op_class = 6'h28;
        `SFC_OP_BUF_READ:                              op_class = 6'h29;
        `SFC_OP_BLOCK_ERASE, `SFC_OP_PAGE_XFER, `SFC_OP_REWRITE, `SFC_OP_COMPARE,
        `SFC_OP_PAGE_ERASE, `SFC_OP_BUF_PROG_E, `SFC_OP_BUF_PROG:
                                                       op_class = 6'h30;
        `SFC_OP_SEC_READ, `SFC_OP_SECT_ERASE:          op_class = 6'h20;
        default:                                       op_class = 6'h00;
      endcase
    end
  endfunction

  function is_known;
    input [7:0] op;
    begin
      is_known = (op_class(op) != 6'h00) || (op == `SFC_OP_IDENT) ||
                 (op == `SFC_OP_DEEP_DOWN) || (op == `SFC_OP_RESUME) ||
                 (op == `SFC_OP_STATUS);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  wire [2:0] pins_s;
  sfc_sync #(.W(3)) u_sync (
    .clk (sys_clk),
    .rst (sys_rst),
    .d   ({cs_n, sck, si}),
    .q   (pins_s)
  );
  wire cs_s  = pins_s[2];
  wire sck_s = pins_s[1];
  wire si_s  = pins_s[0];

  reg        cs_d_r;
  reg        sck_d_r;
  reg [3:0]  st_r;
  reg [2:0]  bit_r;
  reg [1:0]  byte_r;
  reg [7:0]  shift_r;
  reg [23:0] addr_r;
  reg [5:0]  cls_r;
  reg [2:0]  dum_r;
  reg [31:0] puw_cnt_r;

  wire cs_fall  = cs_d_r & ~cs_s;
  wire cs_rise  = ~cs_d_r & cs_s;
  // In mode 0 data is taken on the rising edge; mode 3 idles high and also samples on rising.
  wire sck_rise = ~sck_d_r & sck_s & ~cs_s;
  wire [7:0] byte_in = {shift_r[6:0], si_s};
  wire       byte_done = sck_rise && (bit_r == 3'd7);

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // The synchroniser resets low, so the held chip-select level must too;
      // otherwise a false falling edge would start a frame right after reset.
      cs_d_r        <= 1'b0;
      sck_d_r       <= 1'b1;
      st_r          <= S_IDLE;
      bit_r         <= 3'd0;
      byte_r        <= 2'd0;
      shift_r       <= 8'h00;
      addr_r        <= 24'h000000;
      cls_r         <= 6'h00;
      dum_r         <= 3'd0;
      puw_cnt_r     <= 32'h00000000;
      so_out        <= 1'b0;
      so_oe         <= 1'b0;
      mode3_r       <= 1'b1;
      standby_r     <= 1'b1;
      write_ready_r <= 1'b0;
      deep_down_r   <= 1'b0;
      cmd_valid_r   <= 1'b0;
      cmd_op_r      <= 8'h00;
      page_addr_r   <= 9'h000;
      byte_addr_r   <= 9'h000;
      use_page_r    <= 1'b0;
      use_byte_r    <= 1'b0;
      cmd_illegal_r <= 1'b0;
    end else begin
      cs_d_r      <= cs_s;
      sck_d_r     <= sck_s;
      cmd_valid_r <= 1'b0;
      so_out      <= 1'b0;
      so_oe       <= 1'b0;
      if (por_active) begin
        // Frame state, write delay, clock mode and standby are held idle while the supply is below threshold.
        st_r          <= S_IDLE;
        puw_cnt_r     <= 32'h00000000;
        write_ready_r <= 1'b0;
        mode3_r       <= 1'b1;
        standby_r     <= 1'b1;
      end else begin
        // The write delay only runs while the power-on reset is released,
        // so a supply dip restarts it from zero.
        if (!write_ready_r) begin
          if (puw_cnt_r >= PUW_CYCLES - 1)
            write_ready_r <= 1'b1;
          else
            puw_cnt_r <= puw_cnt_r + 32'h00000001;
        end
        // Chip-select edges win over a clock edge in the same cycle, so a
        // cut frame is dropped whole and never shifts in a stray bit.
        if (cs_fall) begin
          mode3_r   <= sck_s;
          standby_r <= 1'b0;
          st_r      <= S_OP;
          bit_r     <= 3'd0;
          byte_r    <= 2'd0;
        end else if (cs_rise) begin
          st_r      <= S_IDLE;
          standby_r <= 1'b1;
        end else if (sck_rise) begin
          shift_r <= byte_in;
          bit_r   <= bit_r + 3'd1;
          case (st_r)
            S_OP: begin
              if (byte_done) begin
                cmd_op_r <= byte_in;
                cls_r    <= op_class(byte_in);
                byte_r   <= 2'd0;
                if (op_class(byte_in) != 6'h00) begin
                  st_r <= S_ADDR;
                end else begin
                  st_r          <= S_IDLE;
                  cmd_illegal_r <= ~is_known(byte_in);
                  cmd_valid_r   <= is_known(byte_in);
                  use_page_r    <= 1'b0;
                  use_byte_r    <= 1'b0;
                  if (byte_in == `SFC_OP_DEEP_DOWN)
                    deep_down_r <= 1'b1;
                  else if (byte_in == `SFC_OP_RESUME)
                    deep_down_r <= 1'b0;
                end
              end
            end
            S_ADDR: begin
              if (byte_done) begin
                addr_r <= {addr_r[15:0], byte_in};
                byte_r <= byte_r + 2'd1;
                if (byte_r == 2'd2) begin
                  dum_r <= cls_r[2:0];
                  st_r  <= (cls_r[2:0] != 3'd0) ? S_DUMY : S_IDLE;
                  if (cls_r[2:0] == 3'd0) begin
                    cmd_valid_r   <= 1'b1;
                    cmd_illegal_r <= 1'b0;
                    // The last address byte is still arriving, so the page sits
                    // in the low ten bits of the two bytes already held.
                    page_addr_r   <= addr_r[9:1];
                    byte_addr_r   <= {addr_r[0], byte_in};
                    use_page_r    <= cls_r[4];
                    use_byte_r    <= cls_r[3];
                    // Block-level commands keep only the five upper page bits.
                    if (cmd_op_r == `SFC_OP_BLOCK_ERASE)
                      page_addr_r <= {addr_r[9:5], 4'h0};
                  end
                end
              end
            end
            S_DUMY: begin
              if (byte_done) begin
                dum_r <= dum_r - 3'd1;
                if (dum_r == 3'd1) begin
                  st_r          <= S_IDLE;
                  cmd_valid_r   <= 1'b1;
                  cmd_illegal_r <= 1'b0;
                  page_addr_r   <= addr_r[`SFC_PAGE_MSB:`SFC_PAGE_LSB];
                  byte_addr_r   <= addr_r[`SFC_BYTE_MSB:0];
                  use_page_r    <= cls_r[4];
                  use_byte_r    <= cls_r[3];
                end
              end
            end
            default: st_r <= S_IDLE;
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: sfc_frame_asserts.sv */
// Concurrent checks on the ports of the serial flash command framer.
`timescale 1ns/100ps
`default_nettype none
module sfc_frame_chk #(
  parameter PUW_CYCLES = 50
) (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       por_active,
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic       so_oe,
  input wire logic       mode3_r,
  input wire logic       standby_r,
  input wire logic       write_ready_r,
  input wire logic       deep_down_r,
  input wire logic       cmd_valid_r,
  input wire logic [7:0] cmd_op_r
);
  ////////////////////////////////////////////////////////////////////////////////
  // Counts cycles since power-on reset fell; it saturates so it never wraps.
  int unsigned low_cnt_r;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst || por_active)
      low_cnt_r <= 0;
    else if (low_cnt_r < PUW_CYCLES + 8)
      low_cnt_r <= low_cnt_r + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  so_hiz_a: assert property (!so_oe) else $error("output enabled");
  pulse_one_a: assert property (cmd_valid_r |=> !cmd_valid_r) else $error("long pulse");
  por_quiet_a: assert property (por_active [*3] |-> !cmd_valid_r)
    else $error("command in reset");
  idle_quiet_a: assert property (cs_n [*4] |-> !cmd_valid_r)
    else $error("command while deselected");
  mode_pick_a: assert property ($fell(cs_n) |-> ##6 mode3_r == $past(sck, 6))
    else $error("wrong clock mode");
  mode_rst_a: assert property ($fell(sys_rst) |-> mode3_r) else $error("mode not 3");
  ready_early_a: assert property ($rose(write_ready_r) |->
    low_cnt_r inside {[PUW_CYCLES-2:PUW_CYCLES+2]}) else $error("write ready early");
  ready_late_a: assert property (low_cnt_r >= PUW_CYCLES + 4 |-> write_ready_r)
    else $error("write ready late");
  stby_idle_a: assert property (cs_n [*6] ##0 !deep_down_r |-> standby_r)
    else $error("not in standby");
  deep_move_a: assert property ($changed(deep_down_r) |->
    cmd_op_r == (deep_down_r ? 8'hb9 : 8'hab)) else $error("bad power-down change");
  cover property (cmd_valid_r && cmd_op_r == 8'hd2);
  cover property ($rose(write_ready_r));
  cover property ($fell(deep_down_r));
endmodule
bind sfc_frame sfc_frame_chk #(.PUW_CYCLES(PUW_CYCLES)) chk_u (.sys_clk(sys_clk),
  .sys_rst(sys_rst), .por_active(por_active), .cs_n(cs_n), .sck(sck), .so_oe(so_oe),
  .mode3_r(mode3_r), .standby_r(standby_r), .write_ready_r(write_ready_r),
  .deep_down_r(deep_down_r), .cmd_valid_r(cmd_valid_r), .cmd_op_r(cmd_op_r));
`default_nettype wire

/* File: sfc_host_model.sv */
// Host serial controller that frames commands towards the flash device.
`timescale 1ns/100ps
`default_nettype none
module sfc_host (
  input  wire logic sys_clk,
  output var  logic cs_n,
  output var  logic sck,
  output var  logic si
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b1;
    si = 1'b0;
  end
  // Half a serial clock period, 160 ns; all changes land on falling system edges.
  task automatic half();
    repeat (4) @(negedge sys_clk);
  endtask
  // Sends the first nbits of bits, MSB first; sck stands at idle outside the frame.
  task automatic frame(input logic idle, input int nbits, input logic [63:0] bits);
    sck = idle;
    half();
    cs_n = 1'b0;
    half();
    for (int i = 0; i < nbits; i++) begin
      sck = 1'b0;
      si = bits[63-i];
      half();
      sck = 1'b1;
      half();
    end
    sck = idle;
    half();
    cs_n = 1'b1;
    si = ~si;
    half();
  endtask
endmodule
`default_nettype wire

/* File: sfc_tb.sv */
// Self-checking testbench of the serial flash command framer.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic sys_clk, sys_rst, por_active, so_out, so_oe, mode3_r, standby_r, write_ready_r;
  logic deep_down_r, cmd_valid_r, use_page_r, use_byte_r, cmd_illegal_r;
  logic [7:0] cmd_op_r;
  logic [8:0] page_addr_r, byte_addr_r;
  wire cs_n, sck, si;
  int miscompares, checked, pulses;
  localparam logic [7:0] OPS [21] = '{8'h03, 8'h0b, 8'h50, 8'h53, 8'h58, 8'h60, 8'h77,
    8'h7c, 8'h81, 8'h82, 8'h83, 8'h84, 8'h88, 8'hd1, 8'hd2, 8'hd4, 8'he8, 8'h9f, 8'hd7,
    8'hb9, 8'hab};
  sfc_frame #(.PUW_CYCLES(50)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .por_active(por_active), .cs_n(cs_n), .sck(sck), .si(si), .so_out(so_out),
    .so_oe(so_oe), .mode3_r(mode3_r), .standby_r(standby_r), .write_ready_r(write_ready_r),
    .deep_down_r(deep_down_r), .cmd_valid_r(cmd_valid_r), .cmd_op_r(cmd_op_r),
    .page_addr_r(page_addr_r), .byte_addr_r(byte_addr_r), .use_page_r(use_page_r),
    .use_byte_r(use_byte_r), .cmd_illegal_r(cmd_illegal_r));
  sfc_host host_u (.sys_clk(sys_clk), .cs_n(cs_n), .sck(sck), .si(si));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (cmd_valid_r === 1'b1) pulses++;
  task automatic chk(input logic ok, input string what);
    checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask
  task automatic finish_test();
    $display("miscompares=%0d checked=%0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_power();
    int p0;
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'b0;
    chk(mode3_r === 1'b1 && standby_r === 1'b1, "reset state");
    chk(so_oe === 1'b0 && so_out === 1'b0, "output driven");
    p0 = pulses;
    host_u.frame(1'b1, 8, {8'h9f, 56'h0});
    chk(pulses == p0, "command taken in reset");
    por_active = 1'b0;
    repeat (45) @(negedge sys_clk);
    chk(write_ready_r === 1'b0, "write ready early");
    repeat (10) @(negedge sys_clk);
    chk(write_ready_r === 1'b1, "write ready late");
    repeat (25000) @(negedge sys_clk);
  endtask
  // Reserved bits are sent as ones so that a decoder reading them is caught.
  task automatic t_decode();
    logic [7:0] op;
    logic pg_on, by_on;
    int p0, nb;
    for (int i = 0; i < 21; i++) begin
      op = OPS[i];
      pg_on = op inside {8'h03, 8'h0b, 8'h50, 8'h53, 8'h58, 8'h60, 8'h81, 8'h82, 8'h83,
        8'h88, 8'hd2, 8'he8};
      by_on = op inside {8'h03, 8'h0b, 8'h82, 8'h84, 8'hd1, 8'hd2, 8'hd4, 8'he8};
      nb = (i < 17) ? 32 : 8;
      nb += (op inside {8'h0b, 8'hd4}) ? 8 : (op inside {8'hd2, 8'he8}) ? 32 : 0;
      p0 = pulses;
      host_u.frame(i[0], nb, {op, 6'h3f, 9'h1a5, 9'h0c3, 32'h0});
      chk(pulses == p0 + 1 && cmd_op_r === op, "opcode not framed");
      chk(mode3_r === i[0], "clock mode");
      if (i < 17) chk(use_page_r === pg_on, "page use");
      if (i < 17) chk(use_byte_r === by_on, "byte use");
      if (pg_on) chk(page_addr_r === (op == 8'h50 ? 9'h1a0 : 9'h1a5), "page");
      if (by_on) chk(byte_addr_r === 9'h0c3, "byte");
      if (i > 18) chk(deep_down_r === (op == 8'hb9), "power-down");
      if (i > 16) chk(cmd_illegal_r === 1'b0, "known opcode refused");
    end
  endtask
  task automatic t_abort();
    int p0;
    p0 = pulses;
    host_u.frame(1'b1, 32, {8'h0b, 6'h0, 9'h1a5, 9'h0c3, 32'h0});
    host_u.frame(1'b0, 20, {8'h03, 56'h0});
    chk(pulses == p0, "partial frame taken");
    host_u.frame(1'b1, 8, {8'h00, 56'h0});
    chk(pulses == p0 && cmd_illegal_r === 1'b1, "unknown opcode taken");
    host_u.frame(1'b0, 8, {8'hd7, 56'h0});
    chk(pulses == p0 + 1 && mode3_r === 1'b0, "frame after abort");
    chk(cmd_illegal_r === 1'b0, "status read refused");
    sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(mode3_r === 1'b1 && standby_r === 1'b1, "state after reset");
    chk(so_oe === 1'b0, "output after reset");
    host_u.frame(1'b0, 8, {8'h9f, 56'h0});
    chk(pulses == p0 + 2 && cmd_op_r === 8'h9f, "frame after reset");
    chk(mode3_r === 1'b0, "mode after reset frame");
  endtask
  initial begin
    sys_rst = 1'b1;
    por_active = 1'b1;
    t_power();
    t_decode();
    t_abort();
    finish_test();
  end
  initial begin
    #3ms;
    miscompares++;
    finish_test();
  end
endmodule
`default_nettype wire
